// >>> dv/owd_host_model.sv
// host model at the far end of the debug pin
`timescale 1ns/10ps
module owd_host_model #(
  parameter int P = 16
) (
  input wire logic core_clk,
  input wire logic pin,
  output logic hostOe
);
  initial hostOe = 1'b0;
  // low start, data lsb first, stop; rate clock/P inside clock/512..clock/4
  task automatic send(input logic [7:0] b, input logic stopBit);
    logic [9:0] f;
    f = {stopBit, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      hostOe <= ~f[i];
      repeat (P) @(posedge core_clk);
    end
    if (!stopBit) hostOe <= 1'b0;
  endtask
  // break on attach or after errors, then 80H again
  task automatic holdLow(input int n);
    hostOe <= 1'b1;
    repeat (n) @(posedge core_clk);
    hostOe <= 1'b0;
  endtask
  // stays released while the device sends
  task automatic recv(output logic [7:0] b);
    int t = 0;
    while (pin !== 1'b0 && t < 1000) begin
      @(posedge core_clk);
      t++;
    end
    repeat (P / 2) @(posedge core_clk);
    for (int k = 0; k < 8; k++) begin
      repeat (P) @(posedge core_clk);
      b[k] = pin;
    end
    repeat (2 * P) @(posedge core_clk);
  endtask
endmodule // owd_host_model

// >>> dv/test_one_wire_debug_port.sv
// self-checking bench of the one-wire debug port
`timescale 1ns/10ps
module test_one_wire_debug_port;
  import owd_pkg::*;
  localparam int P = 16;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic dbgPinOut, dbgPinOe, hostOe, pin;
  owd_bus_req_s busReq = '0;
  logic [DATA_W-1:0] busRdata, d, e;
  owd_cpu_in_s cpuIn = '0;
  owd_cpu_out_s cpuOut;
  int n_errors = 0;
  int checks_done = 0;
  logic [7:0] b, r;
  always #5 core_clk = ~core_clk;
  // open-drain wire with pull-up
  assign pin = ~(dbgPinOe | hostOe);
  owd_debug_port uut (.core_clk(core_clk), .arst_n(arst_n), .dbgPinIn(pin), .dbgPinOut(dbgPinOut),
    .dbgPinOe(dbgPinOe), .busReq(busReq), .busRdata(busRdata), .cpuIn(cpuIn), .cpuOut(cpuOut));
  owd_host_model #(.P(P)) host (.core_clk(core_clk), .pin(pin), .hostOe(hostOe));
  function automatic logic [15:0] expBaud(input int span);
    return 16'(span >> CAL_SHIFT);
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] v);
    busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge core_clk);
    busReq <= '0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [15:0] v);
    busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge core_clk);
    busReq <= '0;
    #1 v = busRdata;
    @(posedge core_clk);
  endtask
  task automatic trap(input logic [7:0] op);
    cpuIn <= '{decode: 1'b1, opcode: op, pc: 16'($urandom), stopMode: 1'b0};
    @(posedge core_clk);
    cpuIn <= '0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic errBreak();
    int n = 0;
    int t = 0;
    // skip short start-bit pulses of a character the device is still sending
    while (n <= 2 * P && t < 4000) begin
      n = 0;
      while (dbgPinOe !== 1'b1 && t < 4000) begin
        @(posedge core_clk);
        t++;
      end
      while (dbgPinOe === 1'b1 && n < 5000) begin
        @(posedge core_clk);
        n++;
      end
    end
    check(16'(n), 16'h1000);
    repeat (4) @(posedge core_clk);
  endtask
  task automatic end_sim();
    if (n_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #400000;
    n_errors++;
    end_sim();
  end
  initial begin
    b = 8'($urandom(32'haed8));
    fork host.holdLow(8); join_none
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd(ADDR_STAT, d);
    check(d & 16'h0001, 16'h0001);
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    rd(ADDR_STAT, d);
    check(d & 16'h0001, 16'h0000);
    wr(ADDR_CNT, 16'h1234);
    rd(ADDR_CNT, d);
    check(d, CNT_READ_IDLE);
    host.send(8'h80, 1'b1);
    rd(ADDR_BAUD, d);
    check(d, expBaud(8 * P));
    for (int i = 0; i < 3; i++) begin
      b = (i == 0) ? 8'hfe : 8'($urandom) | 8'h01;
      host.send(b, 1'b1);
      rd(ADDR_RXD, d);
      check(d & 16'h00ff, {8'h00, b});
    end
    for (int i = 0; i < 2; i++) begin
      b = (i == 0) ? 8'h00 : 8'($urandom);
      wr(ADDR_TXD, {8'h00, b});
      host.recv(r);
      check({8'h00, r}, {8'h00, b});
    end
    check(16'(dbgPinOut), 16'h0000);
    wr(ADDR_CTRL, 16'h0001);
    repeat (3) @(posedge core_clk);
    check(16'({cpuOut.fetchStop, cpuOut.haltExit, cpuOut.wdtRefresh}), 16'h0007);
    d = 16'($urandom);
    wr(ADDR_CNT, d);
    rd(ADDR_CNT, e);
    check(e, d);
    for (int k = 0; k < 3; k++) begin
      fork
        errBreak();
        case (k)
          0: host.holdLow(10 * P);
          1: host.send(8'h3c, 1'b0);
          default: begin
            wr(ADDR_TXD, 16'h00ff);
            repeat (2 * P) @(posedge core_clk);
            host.holdLow(P);
          end
        endcase
      join
      rd(ADDR_STAT, d);
      check(d & 16'h00e5, (16'h0020 << k) | 16'h0001);
      wr(ADDR_STAT, 16'h00e0);
      host.send(8'h80, 1'b1);
    end
    wr(ADDR_CNT, 16'h0020);
    wr(ADDR_CTRL, 16'h0010);
    repeat (60) @(posedge core_clk);
    rd(ADDR_STAT, d);
    check(d & 16'h0001, 16'h0001);
    // pick cycle-count mode while still in debug, so the exit below clears the counter
    wr(ADDR_CTRL, 16'h0009);
    wr(ADDR_CNT, 16'h1234);
    wr(ADDR_CTRL, 16'h0008);
    repeat (20) @(posedge core_clk);
    wr(ADDR_CTRL, 16'h0009);
    rd(ADDR_CNT, d);
    // 22 clocks pass between the exit edge and the re-entry edge
    check(d, 16'h0016);
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CTRL, (i == 1) ? 16'h0000 : 16'h0002);
      trap((i == 0) ? 8'($urandom) | 8'h01 : HALT_TRAP_OPCODE);
      rd(ADDR_STAT, d);
      check(d & 16'h0001, 16'(i == 2));
    end
    wr(ADDR_CTRL, 16'h0006);
    trap(HALT_TRAP_OPCODE);
    rd(ADDR_STAT, d);
    check(d & 16'h0003, 16'h0002);
    check(16'(cpuOut.loopOnBrk), 16'h0001);
    rd(ADDR_CNT, e);
    check(e, CNT_READ_IDLE);
    wr(ADDR_CTRL, 16'h0002);
    trap(HALT_TRAP_OPCODE);
    rd(ADDR_STAT, d);
    check(d & 16'h0003, 16'h0001);
    cpuIn.stopMode <= 1'b1;
    @(posedge core_clk);
    fork host.holdLow(2); join_none
    for (int t = 0; t < 20 && cpuOut.sysResetReq !== 1'b1; t++) @(posedge core_clk);
    check(16'(cpuOut.sysResetReq), 16'h0001);
    end_sim();
  end
endmodule // test_one_wire_debug_port

// >>> rtl/owd_debug_port.sv
// one-wire debug port: serial link, autobaud, break handling and debug controller
// What this block does
// - one open-drain pin; never transmit while receiving
// - characters: one low start, eight data LSB first, one high stop
// - measure low span of 80H (start plus seven bits) to set bit period
// - nine or more low bit times is a break; autobaud restarts
// - low stop bit is framing error; low while releasing is collision
// - on any serial error abort, drive 4096-cycle low break, reset autobaud
// - host break resets baud logic only; control and debug mode kept
// - debugger held in reset until pin returns high; a host low during transmit is flagged as a collision, not a break
// - in debug mode fetch stops, halt exits, watchdog refreshed
// - debug entry: flag write, breakpoint, PC match, counter reaching 0000H
// - pin low when leaving reset enters debug mode directly
// - debug exit: flag cleared, power-on, brown-out or external reset
// - pin driven low in stop mode requests full system reset
// - halt-trap 00H enters debug if breakpoints enabled, else no-operation
// - with break-loop enabled, CPU loops on halt-trap servicing interrupts
// - idle bit shows looping; clearing loop enable enters debug on return
// - most commands blocked while looping; need debug mode
// - cycle counter runs after debug exit, stops on entry or at FFFFH
// - cycle-count mode clears counter to 0000H on each debug exit
// - outside debug mode counter writes discarded, reads return FFFFH
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
module owd_debug_port (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic dbgPinIn,
  output logic dbgPinOut,
  output logic dbgPinOe,
  input owd_pkg::owd_bus_req_s busReq,
  output logic [owd_pkg::DATA_W-1:0] busRdata,
  input owd_pkg::owd_cpu_in_s cpuIn,
  output owd_pkg::owd_cpu_out_s cpuOut
);
  import owd_pkg::*;

  // ===========================================================================
  // declarations
  owd_state_e state, next_state;
  owd_cnt_mode_e cntMode;
  logic pinQ, fallEdge, riseEdge;
  logic [LOW_W-1:0] lowCnt, brkThresh;
  logic [BIT_W-1:0] bitPer, calPer, tmrLoadVal;
  logic [3:0] bitIdx;
  logic [7:0] rxShift, txShift, rxData;
  logic [BRK_W-1:0] brkCnt, brkRun;
  logic rxValid, brkErr, frameErr, collErr;
  logic tick, tmrLoad, calOk, hostBreak, frameBad, collision, serialErr, txStart, rxStart;
  logic debugMode, brkEn, loopEn, looping, strapDone;
  logic [DATA_W-1:0] cycleCnt, statWord, rdMux;
  logic ctrlWr, cntWr, brkHit, enterBrk, startLoop, cntZeroHit, pcHit, enterDbg, exitDbg;

  // ===========================================================================
  // line events and error detection
  assign fallEdge = pinQ && !dbgPinIn;
  assign riseEdge = !pinQ && dbgPinIn;
  assign calPer = lowCnt[CAL_SHIFT +: BIT_W];
  assign calOk = (state == ST_CAL) && riseEdge && (lowCnt >= CAL_MIN_LOW) && (lowCnt <= CAL_MAX_LOW);
  assign hostBreak = (state == ST_IDLE || state == ST_RX) && !dbgPinIn && (lowCnt >= brkThresh);
  assign frameBad = (state == ST_RX) && tick && (bitIdx == STOP_IDX) && !dbgPinIn;
  assign collision = (state == ST_TX) && tick && !dbgPinOe && !dbgPinIn;
  assign serialErr = hostBreak || frameBad || collision;
  assign rxStart = (state == ST_IDLE) && fallEdge && !hostBreak;
  // transmit only from idle with the line high, never while a character comes in
  assign txStart = (state == ST_IDLE) && busReq.wr && (busReq.addr == ADDR_TXD) && dbgPinIn && pinQ;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pinQ <= 1'b1;
    end else begin
      pinQ <= dbgPinIn;
    end
  end

  // continuous low span, saturating
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lowCnt <= '0;
    end else if (dbgPinIn) begin
      lowCnt <= '0;
    end else if (lowCnt != LOW_SAT) begin
      lowCnt <= lowCnt + 16'h0001;
    end
  end

  // ===========================================================================
  // link state machine
  always_comb begin
    next_state = state;
    case (state)
      ST_CAL: begin
        if (calOk) begin
          next_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (hostBreak) begin
          next_state = ST_BRK;
        end else if (rxStart) begin
          next_state = ST_RX;
        end else if (txStart) begin
          next_state = ST_TX;
        end
      end
      ST_RX: begin
        if (serialErr) begin
          next_state = ST_BRK;
        end else if (tick && (bitIdx == STOP_IDX)) begin
          next_state = ST_IDLE;
        end else if (tick && (bitIdx == 4'h0) && dbgPinIn) begin
          next_state = ST_IDLE;
        end
      end
      ST_TX: begin
        if (collision) begin
          next_state = ST_BRK;
        end else if (tick && (bitIdx == STOP_IDX)) begin
          next_state = ST_IDLE;
        end
      end
      ST_BRK: begin
        if (brkCnt == '0) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // link logic stays reset until the line is released; autobaud restarts
        if (dbgPinIn) begin
          next_state = ST_CAL;
        end
      end
      default: begin
        next_state = ST_CAL;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_CAL;
    end else begin
      state <= next_state;
    end
  end

  // ===========================================================================
  // autobaud: bit period is one eighth of the measured low span
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bitPer <= MAX_BIT_CYCLES;
      brkThresh <= LOW_SAT;
    end else if (calOk) begin
      bitPer <= calPer;
      brkThresh <= 16'({6'h0, calPer} * BRK_BITS);
    end
  end

  // ===========================================================================
  // bit timer: on receive half period to the start-bit centre, on transmit a whole one, then whole periods
  assign tmrLoad = (state == ST_IDLE) && (next_state == ST_RX || next_state == ST_TX);
  assign tmrLoadVal = (next_state == ST_RX) ? ((bitPer >> 1) - 10'h001) : (bitPer - 10'h001);

  owd_timer #(
    .W(BIT_W)
  ) u_bit_timer (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .load(tmrLoad),
    .loadVal(tmrLoadVal),
    .reloadVal(bitPer - 10'h001),
    .en(state == ST_RX || state == ST_TX),
    .tick(tick)
  );

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bitIdx <= '0;
    end else if (tmrLoad) begin
      bitIdx <= '0;
    end else if (tick) begin
      bitIdx <= bitIdx + 4'h1;
    end
  end

  // ===========================================================================
  // receiver: data bits arrive least significant first
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxShift <= '0;
      rxData <= '0;
    end else if (state == ST_RX && tick) begin
      if (bitIdx != 4'h0 && bitIdx <= LAST_DATA_IDX) begin
        rxShift <= {dbgPinIn, rxShift[7:1]};
      end
      if (bitIdx == STOP_IDX && dbgPinIn) begin
        rxData <= rxShift;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxValid <= 1'b0;
    end else if (state == ST_RX && next_state == ST_IDLE && bitIdx == STOP_IDX) begin
      rxValid <= 1'b1;
    end else if (busReq.rd && busReq.addr == ADDR_RXD) begin
      rxValid <= 1'b0;
    end
  end

  // ===========================================================================
  // transmitter and break driver; the pin is only ever pulled low
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      txShift <= '0;
      dbgPinOe <= 1'b0;
    end else if (next_state == ST_BRK) begin
      dbgPinOe <= 1'b1;
    end else if (txStart) begin
      txShift <= busReq.wdata[7:0];
      dbgPinOe <= 1'b1;
    end else if (state == ST_TX && next_state == ST_TX && tick) begin
      if (bitIdx < LAST_DATA_IDX) begin
        dbgPinOe <= !txShift[0];
        txShift <= {1'b0, txShift[7:1]};
      end else begin
        dbgPinOe <= 1'b0;
      end
    end else if (next_state != ST_TX) begin
      dbgPinOe <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dbgPinOut <= 1'b0;
    end else begin
      dbgPinOut <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      brkCnt <= '0;
    end else if (next_state == ST_BRK && state != ST_BRK) begin
      brkCnt <= BRK_CYCLES - 13'h0001;
    end else if (state == ST_BRK) begin
      brkCnt <= brkCnt - 13'h0001;
    end
  end

  // sticky error flags, write one to clear, a new error wins
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      brkErr <= 1'b0;
      frameErr <= 1'b0;
      collErr <= 1'b0;
    end else begin
      brkErr <= hostBreak || (brkErr && !(busReq.wr && busReq.addr == ADDR_STAT && busReq.wdata[STA_BRK]));
      frameErr <= frameBad || (frameErr && !(busReq.wr && busReq.addr == ADDR_STAT && busReq.wdata[STA_FRM]));
      collErr <= collision || (collErr && !(busReq.wr && busReq.addr == ADDR_STAT && busReq.wdata[STA_COL]));
    end
  end

  // ===========================================================================
  // debug controller
  assign ctrlWr = busReq.wr && (busReq.addr == ADDR_CTRL);
  assign cntWr = busReq.wr && (busReq.addr == ADDR_CNT);
  assign brkHit = cpuIn.decode && (cpuIn.opcode == HALT_TRAP_OPCODE) && brkEn;
  assign enterBrk = brkHit && !loopEn;
  assign startLoop = brkHit && loopEn && !debugMode;
  assign cntZeroHit = (cntMode == CM_DOWN) && !debugMode && (cycleCnt == CNT_ONE);
  assign pcHit = (cntMode == CM_PCMATCH) && !debugMode && cpuIn.decode && (cpuIn.pc == cycleCnt);
  assign enterDbg = (ctrlWr && busReq.wdata[CTL_DBG]) || enterBrk || cntZeroHit || pcHit;
  assign exitDbg = ctrlWr && !busReq.wdata[CTL_DBG] && debugMode && !enterDbg;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      strapDone <= 1'b0;
    end else begin
      strapDone <= 1'b1;
    end
  end

  // any system reset lands on arst_n and ends debug mode; serial breaks never touch it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      debugMode <= 1'b0;
    end else if (!strapDone) begin
      debugMode <= !dbgPinIn;
    end else if (enterDbg) begin
      debugMode <= 1'b1;
    end else if (exitDbg) begin
      debugMode <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      brkEn <= 1'b0;
      loopEn <= 1'b0;
      cntMode <= CM_OFF;
    end else if (ctrlWr) begin
      brkEn <= busReq.wdata[CTL_BRKEN];
      loopEn <= busReq.wdata[CTL_LOOP];
      cntMode <= owd_cnt_mode_e'(busReq.wdata[CTL_MODE +: 2]);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      looping <= 1'b0;
    end else if (enterDbg) begin
      looping <= 1'b0;
    end else if (startLoop) begin
      looping <= 1'b1;
    end
  end

  // counter writes only land in debug mode, which looping never is
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cycleCnt <= CNT_ZERO;
    end else if (cntWr && debugMode) begin
      cycleCnt <= busReq.wdata;
    end else if (exitDbg && cntMode == CM_CYCLES) begin
      cycleCnt <= CNT_ZERO;
    end else if (!debugMode && cntMode == CM_CYCLES && cycleCnt != CNT_SAT) begin
      cycleCnt <= cycleCnt + 16'h0001;
    end else if (!debugMode && cntMode == CM_DOWN && cycleCnt != CNT_ZERO) begin
      cycleCnt <= cycleCnt - 16'h0001;
    end
  end

  // CPU side controls
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cpuOut <= '0;
    end else begin
      cpuOut.fetchStop <= debugMode;
      cpuOut.haltExit <= debugMode;
      cpuOut.wdtRefresh <= debugMode;
      cpuOut.loopOnBrk <= looping && loopEn;
      cpuOut.sysResetReq <= cpuIn.stopMode && fallEdge;
    end
  end

  // ===========================================================================
  // register read port, data valid the cycle after the strobe only
  always_comb begin
    statWord = '0;
    statWord[STA_DBG] = debugMode;
    statWord[STA_IDLE] = looping;
    statWord[STA_CAL] = (state == ST_IDLE || state == ST_RX || state == ST_TX);
    statWord[STA_RXV] = rxValid;
    statWord[STA_TXB] = (state == ST_TX);
    statWord[STA_BRK] = brkErr;
    statWord[STA_FRM] = frameErr;
    statWord[STA_COL] = collErr;
    case (busReq.addr)
      ADDR_CTRL: rdMux = {11'h000, cntMode, loopEn, brkEn, debugMode};
      ADDR_STAT: rdMux = statWord;
      ADDR_CNT: rdMux = debugMode ? cycleCnt : CNT_READ_IDLE;
      ADDR_RXD: rdMux = {8'h00, rxData};
      ADDR_BAUD: rdMux = {6'h00, bitPer};
      default: rdMux = '0;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      busRdata <= '0;
    end else begin
      busRdata <= busReq.rd ? rdMux : '0;
    end
  end

  // ===========================================================================
  // checks
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      brkRun <= '0;
    end else if (state == ST_BRK) begin
      brkRun <= brkRun + 13'h0001;
    end else begin
      brkRun <= '0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence s_brk_end;
    (state == ST_BRK) && (next_state == ST_HOLD);
  endsequence

  property p_half_duplex;
    (state == ST_RX) |-> !dbgPinOe;
  endproperty
  a_half_duplex: assert property (p_half_duplex) else $error("pin driven while receiving");

  property p_tx_start;
    txStart |=> (state == ST_TX) && dbgPinOe ##1 dbgPinOe;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("start bit not driven low");

  property p_cal;
    calOk |=> (bitPer == $past(calPer)) && (state == ST_IDLE);
  endproperty
  a_cal: assert property (p_cal) else $error("bit period not taken from low span");

  property p_host_break;
    hostBreak |=> (state == ST_BRK) && dbgPinOe && brkErr;
  endproperty
  a_host_break: assert property (p_host_break) else $error("host break not answered");

  property p_frame;
    frameBad |=> frameErr && (state == ST_BRK);
  endproperty
  a_frame: assert property (p_frame) else $error("framing error missed");

  property p_brk_len;
    s_brk_end |-> (brkRun == BRK_CYCLES - 13'h0001) && dbgPinOe;
  endproperty
  a_brk_len: assert property (p_brk_len) else $error("break length wrong");

  property p_keep_ctrl;
    (serialErr && !busReq.wr && !enterDbg) |=> (debugMode == $past(debugMode)) && (brkEn == $past(brkEn));
  endproperty
  a_keep_ctrl: assert property (p_keep_ctrl) else $error("serial error touched control");

  property p_hold;
    (state == ST_HOLD && !dbgPinIn) |=> (state == ST_HOLD) && !dbgPinOe;
  endproperty
  a_hold: assert property (p_hold) else $error("released before line high");

  property p_brk_enter;
    (enterBrk && strapDone) |=> debugMode ##1 cpuOut.fetchStop;
  endproperty
  a_brk_enter: assert property (p_brk_enter) else $error("breakpoint did not enter debug");

  property p_nop;
    (strapDone && cpuIn.decode && !brkEn && !debugMode && !ctrlWr && !cntZeroHit && !pcHit) |=> !debugMode;
  endproperty
  a_nop: assert property (p_nop) else $error("disabled halt-trap entered debug");

  property p_cnt_idle_read;
    (busReq.rd && busReq.addr == ADDR_CNT && !debugMode) |=> (busRdata == CNT_READ_IDLE);
  endproperty
  a_cnt_idle_read: assert property (p_cnt_idle_read) else $error("counter read outside debug");

  property p_cnt_clear;
    (exitDbg && cntMode == CM_CYCLES && busReq.wdata[CTL_MODE +: 2] == CM_CYCLES) |=>
      (cycleCnt == CNT_ZERO) ##1 (cycleCnt == CNT_ONE);
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("cycle counter not cleared on exit");

  property p_collision;
    collision |=> collErr && dbgPinOe;
  endproperty
  a_collision: assert property (p_collision) else $error("collision not flagged");
endmodule // owd_debug_port

// >>> rtl/owd_pkg.sv
// shared constants and types of the one-wire debug port
package owd_pkg;

  // ===========================================================================
  // widths
  localparam int DATA_W = 16;
  localparam int ADDR_W = 3;
  localparam int BIT_W = 10;
  localparam int LOW_W = 16;
  localparam int BRK_W = 13;

  // ===========================================================================
  // register offsets (word index on the plain register port)
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_CNT = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_TXD = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_RXD = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_BAUD = 3'h5;

  // ===========================================================================
  // debugger_control_reg fields
  localparam int CTL_DBG = 0;
  localparam int CTL_BRKEN = 1;
  localparam int CTL_LOOP = 2;
  localparam int CTL_MODE = 3;

  // debugger_status_reg fields
  localparam int STA_DBG = 0;
  localparam int STA_IDLE = 1;
  localparam int STA_CAL = 2;
  localparam int STA_RXV = 3;
  localparam int STA_TXB = 4;
  localparam int STA_BRK = 5;
  localparam int STA_FRM = 6;
  localparam int STA_COL = 7;

  // ===========================================================================
  // serial timing
  localparam logic [BIT_W-1:0] MIN_BIT_CYCLES = 10'h004;
  localparam logic [BIT_W-1:0] MAX_BIT_CYCLES = 10'h200;
  localparam int CAL_SHIFT = 3;
  localparam logic [LOW_W-1:0] CAL_MIN_LOW = {3'h0, MIN_BIT_CYCLES, 3'h0};
  localparam logic [LOW_W-1:0] CAL_MAX_LOW = {3'h0, MAX_BIT_CYCLES, 3'h7};
  localparam logic [LOW_W-1:0] LOW_SAT = 16'hffff;
  localparam logic [LOW_W-1:0] BRK_BITS = 16'h0009;
  localparam logic [BRK_W-1:0] BRK_CYCLES = 13'h1000;
  localparam logic [3:0] LAST_DATA_IDX = 4'h8;
  localparam logic [3:0] STOP_IDX = 4'h9;

  // ===========================================================================
  // debug controller constants
  localparam logic [7:0] HALT_TRAP_OPCODE = 8'h00;
  localparam logic [DATA_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [DATA_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [DATA_W-1:0] CNT_SAT = 16'hffff;
  localparam logic [DATA_W-1:0] CNT_READ_IDLE = 16'hffff;

  typedef enum logic [1:0] {
    CM_OFF = 2'h0,
    CM_CYCLES = 2'h1,
    CM_DOWN = 2'h2,
    CM_PCMATCH = 2'h3
  } owd_cnt_mode_e;

  typedef enum logic [5:0] {
    ST_CAL = 6'h01,
    ST_IDLE = 6'h02,
    ST_RX = 6'h04,
    ST_TX = 6'h08,
    ST_BRK = 6'h10,
    ST_HOLD = 6'h20
  } owd_state_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } owd_bus_req_s;

  typedef struct packed {
    logic decode;
    logic [7:0] opcode;
    logic [15:0] pc;
    logic stopMode;
  } owd_cpu_in_s;

  typedef struct packed {
    logic fetchStop;
    logic loopOnBrk;
    logic haltExit;
    logic wdtRefresh;
    logic sysResetReq;
  } owd_cpu_out_s;

endpackage

// >>> rtl/owd_timer.sv
// reloading down-counter that paces serial bit times
`timescale 1ns/10ps
module owd_timer #(
  parameter int W = 10
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic load,
  input wire logic [W-1:0] loadVal,
  input wire logic [W-1:0] reloadVal,
  input wire logic en,
  output logic tick
);
  logic [W-1:0] cnt;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= '0;
    end else if (load) begin
      cnt <= loadVal;
    end else if (en) begin
      if (cnt == '0) begin
        cnt <= reloadVal;
      end else begin
        cnt <= cnt - 1'b1;
      end
    end
  end

  assign tick = en && !load && (cnt == '0);
endmodule // owd_timer
